// ### shared/tca_consts.vh
// constants shared by the transceiver coding and alignment channel
// assumes inclusion by bare name from every design file that needs it
`ifndef TCA_CONSTS_VH
`define TCA_CONSTS_VH
// ****************************************************************
// running disparity and word layout
// ****************************************************************
`define TCA_RD_NEG   1'b0
`define TCA_LANES    4
`define TCA_LW       10
`define TCA_BW       8
`define TCA_WW       40
`define TCA_DW       32
// ****************************************************************
// code table sets, one bit per 5-bit sub-block value
// ****************************************************************
`define TCA_BAL6     32'h167e7ee8
`define TCA_ALT_NEG  32'h00160000
`define TCA_ALT_POS  32'h00006800
`define TCA_KX7      32'h68800000
`define TCA_X7       5'h07
`define TCA_X28      5'h1c
`define TCA_Y0       3'h0
`define TCA_Y3       3'h3
`define TCA_Y4       3'h4
`define TCA_Y7       3'h7
`define TCA_K28_6B   6'h0f
`define TCA_ALT_4B   4'h7
// ****************************************************************
// markers and commas
// ****************************************************************
`define TCA_K28_5    8'hbc
`define TCA_K28_3    8'h7c
`define TCA_CMW      7
`define TCA_COMMA_N  7'h1f
`define TCA_COMMA_P  7'h60
// ****************************************************************
// alignment groups and channel letters
// ****************************************************************
`define TCA_GRP_ALL  4'hf
`define TCA_GRP_LO   4'h3
`define TCA_GRP_HI   4'hc
`define TCA_CH_C     1'b0
`define TCA_CH_D     1'b1
`endif

// ### core/tca_lane_coder.v
// one byte lane of the 8b/10b coder: encode and decode, combinational
// assumes the caller chains running disparity from lane to lane
`timescale 1ns/1ps
`include "tca_consts.vh"
module tca_lane_coder (
	input  wire [7:0] tx_byte,
	input  wire       tx_k,
	input  wire       tx_rd_in,
	output wire [9:0] tx_code,
	output wire       tx_rd_out,
	input  wire [9:0] rx_code,
	input  wire       rx_rd_in,
	output wire [7:0] rx_byte,
	output wire       rx_k,
	output wire       rx_err,
	output wire       rx_rd_out
);
// ****************************************************************
// encoder: returns {rd out, abcdei fghj}
// ****************************************************************
function [10:0] enc;
	input [7:0] d;
	input       k;
	input       rd;
	reg [5:0]  six;
	reg [3:0]  four;
	reg [31:0] bal;
	reg [31:0] an;
	reg [31:0] ap;
	reg        k28;
	reg        u6;
	reg        rd1;
	reg        alt;
	reg        f4;
	reg        u4;
	begin
		bal = `TCA_BAL6;
		an = `TCA_ALT_NEG;
		ap = `TCA_ALT_POS;
		k28 = k & (d[4:0] == `TCA_X28);
		case (d[4:0])
		5'd0: six = 6'h27;  5'd1: six = 6'h1d;  5'd2: six = 6'h2d;
		5'd3: six = 6'h31;  5'd4: six = 6'h35;  5'd5: six = 6'h29;
		5'd6: six = 6'h19;  5'd7: six = 6'h38;  5'd8: six = 6'h39;
		5'd9: six = 6'h25;  5'd10: six = 6'h15; 5'd11: six = 6'h34;
		5'd12: six = 6'h0d; 5'd13: six = 6'h2c; 5'd14: six = 6'h1c;
		5'd15: six = 6'h17; 5'd16: six = 6'h1b; 5'd17: six = 6'h23;
		5'd18: six = 6'h13; 5'd19: six = 6'h32; 5'd20: six = 6'h0b;
		5'd21: six = 6'h2a; 5'd22: six = 6'h1a; 5'd23: six = 6'h3a;
		5'd24: six = 6'h33; 5'd25: six = 6'h26; 5'd26: six = 6'h16;
		5'd27: six = 6'h36; 5'd28: six = 6'h0e; 5'd29: six = 6'h2e;
		5'd30: six = 6'h1e; default: six = 6'h2b;
		endcase
		if (k28)
			six = `TCA_K28_6B;
		u6 = k28 | ~bal[d[4:0]];
		if (rd & (u6 | (d[4:0] == `TCA_X7)))
			six = ~six;
		rd1 = u6 ? ~rd : rd;
		u4 = (d[7:5] == `TCA_Y0) | (d[7:5] == `TCA_Y4) |
		     (d[7:5] == `TCA_Y7);
		if (k28) begin
			case (d[7:5])
			3'd0: four = 4'h4; 3'd1: four = 4'h9; 3'd2: four = 4'h5;
			3'd3: four = 4'h3; 3'd4: four = 4'h2; 3'd5: four = 4'ha;
			3'd6: four = 4'h6; default: four = 4'h8;
			endcase
			if (rd)
				four = ~four;
		end else begin
			case (d[7:5])
			3'd0: four = 4'hb; 3'd1: four = 4'h9; 3'd2: four = 4'h5;
			3'd3: four = 4'hc; 3'd4: four = 4'hd; 3'd5: four = 4'ha;
			3'd6: four = 4'h6; default: four = 4'he;
			endcase
			alt = (d[7:5] == `TCA_Y7) &
			      (k | (~rd1 & an[d[4:0]]) | (rd1 & ap[d[4:0]]));
			if (alt)
				four = `TCA_ALT_4B;
			f4 = u4 | (d[7:5] == `TCA_Y3);
			if (rd1 & f4)
				four = ~four;
		end
		enc = {(u4 ? ~rd1 : rd1), six, four};
	end
endfunction
// ****************************************************************
// decoder: returns {rd out, error, k, byte}
// ****************************************************************
function [10:0] dec;
	input [9:0] code;
	input       rd;
	integer     i;
	reg [8:0]   idx;
	reg [10:0]  e;
	reg [31:0]  kx;
	reg         ok;
	reg         any;
	reg [10:0]  alt;
	begin
		kx = `TCA_KX7;
		ok = 1'b0;
		any = 1'b0;
		dec = {rd, 1'b1, 9'h000};
		alt = {rd, 1'b1, 9'h000};
		for (i = 0; i < 512; i = i + 1) begin
			idx = i[8:0];
			if (~idx[8] | (idx[4:0] == `TCA_X28) |
			    ((idx[7:5] == `TCA_Y7) & kx[idx[4:0]])) begin
				e = enc(idx[7:0], idx[8], rd);
				if ((e[9:0] == code) & ~ok) begin
					ok = 1'b1;
					dec = {e[10], 1'b0, idx};
				end
				e = enc(idx[7:0], idx[8], ~rd);
				if ((e[9:0] == code) & ~any) begin
					any = 1'b1;
					alt = {e[10], 1'b1, idx};
				end
			end
		end
		if (~ok)
			dec = alt;
	end
endfunction
// ****************************************************************
// lane outputs
// ****************************************************************
wire [10:0] tx_res = enc(tx_byte, tx_k, tx_rd_in);
wire [10:0] rx_res = dec(rx_code, rx_rd_in);
assign tx_code = tx_res[9:0];
assign tx_rd_out = tx_res[10];
assign rx_rd_out = rx_res[10];
assign rx_err = rx_res[9];
assign rx_k = rx_res[8];
assign rx_byte = rx_res[7:0];
endmodule // tca_lane_coder

// ### core/tca_channel.v
// one transceiver channel, parallel side: coding, framing, deskew
// assumes fabric config bits and serdes words share the one clock
//
// Behaviour
// - transmit takes a raw 40-bit word or 32 data plus eight control bits
// - coded mode moves 32 data bits and four special flags each way
// - four force inputs, one per lane, force negative running disparity
// - bytes map to 10-bit groups by standard tables; bad groups flagged
// - receive decodes only when enabled, else raw 10-bit groups pass
// - comma search shifts word framing onto the proper boundary
// - receive words pass the alignment stage or bypass it
// - alignment groups are pairs of channels or all four
// - alignment marker is a comma, or /A/ in XAUI mode
// - bypassed channels run alone with their own frame pulse
// - full or half rate chosen separately for transmit and receive
// - transmitter and receiver each power down on their own
// - high-speed and low-speed loopback are both offered
// - modes come from control bits; status is kept for reading
// - channel addressed by block letter and channel letter C or D
// - transmit data and control sampled together on the rising edge
// - force bit one codes its byte from negative running disparity, so never with more zeros than ones
`timescale 1ns/1ps
`include "tca_consts.vh"
module tca_channel #(
	parameter       BLOCK_ID   = 1'b0,
	parameter       CHANNEL_ID = `TCA_CH_C,
	parameter       CHAN_INDEX = 0,
	parameter       PW         = 3,
	parameter       DEPTH      = 8
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        clk_en,
	input  wire        coding_enable,
	input  wire        decode_enable,
	input  wire        align_enable,
	input  wire        fifo_bypass,
	input  wire        group_quad,
	input  wire        xaui_mode,
	input  wire        tx_half_rate,
	input  wire        rx_half_rate,
	input  wire        tx_power_down,
	input  wire        rx_power_down,
	input  wire        loop_high_speed,
	input  wire        loop_low_speed,
	input  wire [31:0] tx_word_data,
	input  wire [3:0]  tx_special_char_flag,
	input  wire [3:0]  force_neg_disparity,
	input  wire [39:0] rx_code_in,
	input  wire        rx_code_valid,
	input  wire [3:0]  peer_marker_seen,
	output reg  [39:0] tx_code_out,
	output reg         tx_code_valid,
	output reg  [39:0] rx_word_data,
	output reg  [3:0]  rx_lane_error,
	output reg         rx_word_valid,
	output reg         rx_frame_pulse,
	output reg         rx_marker_seen,
	output reg         rx_aligned,
	output reg  [1:0]  channel_addr
);
// ****************************************************************
// state
// ****************************************************************
reg          tx_rd;
reg          tx_phase;
reg          rx_rd;
reg          rx_phase;
reg  [39:0]  rx_prev;
reg  [5:0]   rx_off;
reg          st_valid;
reg  [39:0]  st_word;
reg  [3:0]   st_err;
reg          st_marker;
reg          st_comma;
reg  [43:0]  mem [0:DEPTH-1];
reg  [PW-1:0] wr_ptr;
reg  [PW-1:0] rd_ptr;
reg  [PW-1:0] mark_pos;
reg          running;
wire [4:0]   tx_rd_ch;
wire [4:0]   rx_rd_ch;
wire [39:0]  enc_code;
wire [31:0]  dec_byte;
wire [3:0]   dec_k;
wire [3:0]   dec_err;
reg  [39:0]  raw_tx;
reg  [39:0]  dec_word;
reg          marker_hit;
reg          comma_found;
reg  [5:0]   comma_pos;
integer      o;
integer      n;
// ****************************************************************
// paced takes and data sources
// ****************************************************************
wire tx_take = clk_en & ~tx_power_down &
               (~tx_half_rate | tx_phase);
wire [39:0] src = loop_high_speed ? tx_code_out : rx_code_in;
wire src_valid = loop_high_speed ? tx_code_valid : rx_code_valid;
wire rx_take = clk_en & ~rx_power_down & src_valid &
               (~rx_half_rate | rx_phase);
wire [79:0] strm = {rx_prev, src};
wire [39:0] framed = strm[79 - rx_off -: `TCA_WW];
wire fifo_use = ~fifo_bypass & decode_enable;
wire [3:0] grp_mask = group_quad ? `TCA_GRP_ALL :
                      ((CHAN_INDEX < 2) ? `TCA_GRP_LO : `TCA_GRP_HI);
wire release_grp = rx_marker_seen &
                   (&(peer_marker_seen | ~grp_mask));
wire [7:0] marker_byte = xaui_mode ? `TCA_K28_3 : `TCA_K28_5;
// ****************************************************************
// byte lanes, lane 3 first on the line
// ****************************************************************
assign tx_rd_ch[4] = tx_rd;
assign rx_rd_ch[4] = rx_rd;
genvar g;
generate
	for (g = 0; g < `TCA_LANES; g = g + 1) begin : lane
		tca_lane_coder u_coder (
			.tx_byte   (tx_word_data[g*8+7 -: 8]),
			.tx_k      (tx_special_char_flag[g]),
			.tx_rd_in  (force_neg_disparity[g] ? `TCA_RD_NEG :
			            tx_rd_ch[g+1]),
			.tx_code   (enc_code[g*10+9 -: 10]),
			.tx_rd_out (tx_rd_ch[g]),
			.rx_code   (framed[g*10+9 -: 10]),
			.rx_rd_in  (rx_rd_ch[g+1]),
			.rx_byte   (dec_byte[g*8+7 -: 8]),
			.rx_k      (dec_k[g]),
			.rx_err    (dec_err[g]),
			.rx_rd_out (rx_rd_ch[g])
		);
	end
endgenerate
// ****************************************************************
// raw packing, decoded packing, comma search
// ****************************************************************
always @* begin
	marker_hit = 1'b0;
	for (n = 0; n < `TCA_LANES; n = n + 1) begin
		raw_tx[n*10+9 -: 10] = {tx_special_char_flag[n],
		                        force_neg_disparity[n],
		                        tx_word_data[n*8+7 -: 8]};
		dec_word[n*10+9 -: 10] = {1'b0, dec_k[n],
		                          dec_byte[n*8+7 -: 8]};
		if (dec_k[n] & ~dec_err[n] & (dec_byte[n*8+7 -: 8] == marker_byte))
			marker_hit = 1'b1;
	end
end

always @* begin
	comma_found = 1'b0;
	comma_pos = 6'h00;
	for (o = `TCA_WW - 1; o >= 0; o = o - 1) begin
		if ((strm[79 - o -: `TCA_CMW] == `TCA_COMMA_N) |
		    (strm[79 - o -: `TCA_CMW] == `TCA_COMMA_P)) begin
			comma_found = 1'b1;
			comma_pos = o[5:0];
		end
	end
end
// ****************************************************************
// transmit path
// ****************************************************************
always @(posedge clock) begin
	if (rst) begin
		tx_rd <= `TCA_RD_NEG;
		tx_phase <= 1'b0;
		tx_code_out <= 40'h00_0000_0000;
		tx_code_valid <= 1'b0;
		channel_addr <= 2'h0;
	end else if (clk_en) begin
		channel_addr <= {BLOCK_ID[0], CHANNEL_ID[0]};
		tx_phase <= tx_half_rate ? ~tx_phase : 1'b0;
		tx_code_valid <= tx_take;
		if (tx_power_down) begin
			tx_code_out <= 40'h00_0000_0000;
		end else if (tx_take) begin
			if (coding_enable) begin
				tx_code_out <= enc_code;
				tx_rd <= tx_rd_ch[0];
			end else begin
				tx_code_out <= raw_tx;
			end
		end
	end
end
// ****************************************************************
// receive framing and decode stage
// ****************************************************************
always @(posedge clock) begin
	if (rst) begin
		rx_rd <= `TCA_RD_NEG;
		rx_phase <= 1'b0;
		rx_prev <= 40'h00_0000_0000;
		rx_off <= 6'h00;
		rx_aligned <= 1'b0;
		st_valid <= 1'b0;
		st_word <= 40'h00_0000_0000;
		st_err <= 4'h0;
		st_marker <= 1'b0;
		st_comma <= 1'b0;
	end else if (clk_en) begin
		if (src_valid)
			rx_phase <= rx_half_rate ? ~rx_phase : 1'b0;
		st_valid <= rx_take;
		if (rx_power_down)
			rx_aligned <= 1'b0;
		if (rx_take) begin
			rx_prev <= src;
			st_comma <= comma_found;
			if (align_enable & comma_found)
				rx_off <= comma_pos;
			if (align_enable & comma_found)
				rx_aligned <= 1'b1;
			else if (decode_enable & |dec_err)
				rx_aligned <= 1'b0;
			if (decode_enable) begin
				st_word <= dec_word;
				st_err <= dec_err;
				st_marker <= marker_hit;
				rx_rd <= rx_rd_ch[0];
			end else begin
				st_word <= framed;
				st_err <= 4'h0;
				st_marker <= 1'b0;
			end
		end
	end
end
// ****************************************************************
// deskew buffer and output stage
// ****************************************************************
always @(posedge clock) begin
	if (clk_en & st_valid)
		mem[wr_ptr] <= {st_err, st_word};
end

always @(posedge clock) begin
	if (rst) begin
		wr_ptr <= {PW{1'b0}};
		rd_ptr <= {PW{1'b0}};
		mark_pos <= {PW{1'b0}};
		running <= 1'b0;
		rx_marker_seen <= 1'b0;
		rx_word_data <= 40'h00_0000_0000;
		rx_lane_error <= 4'h0;
		rx_word_valid <= 1'b0;
		rx_frame_pulse <= 1'b0;
	end else if (clk_en) begin
		if (st_valid)
			wr_ptr <= wr_ptr + 1'b1;
		if (~fifo_use) begin
			running <= 1'b0;
			rx_marker_seen <= 1'b0;
		end else if (release_grp) begin
			rd_ptr <= mark_pos;
			running <= 1'b1;
			rx_marker_seen <= 1'b0;
		end else if (st_valid & st_marker & ~running & ~rx_marker_seen) begin
			mark_pos <= wr_ptr;
			rx_marker_seen <= 1'b1;
		end
		rx_frame_pulse <= st_valid & st_comma;
		if (loop_low_speed) begin
			rx_word_valid <= tx_take;
			if (tx_take) begin
				rx_word_data <= raw_tx;
				rx_lane_error <= 4'h0;
			end
		end else if (fifo_use) begin
			rx_word_valid <= st_valid & running;
			if (st_valid & running) begin
				rd_ptr <= rd_ptr + 1'b1;
				rx_word_data <= mem[rd_ptr][39:0];
				rx_lane_error <= mem[rd_ptr][43:40];
			end
		end else begin
			rx_word_valid <= st_valid;
			if (st_valid) begin
				rx_word_data <= st_word;
				rx_lane_error <= st_err;
			end
		end
	end
end
endmodule // tca_channel

// ### test/tca_channel_properties.sv
// port assertions for one transceiver channel, bound from the bench top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module tca_channel_properties #(
	parameter BLOCK_ID   = 1'b0,
	parameter CHANNEL_ID = 1'b0
) (
	input wire        clock,
	input wire        rst,
	input wire        clk_en,
	input wire        coding_enable,
	input wire        tx_half_rate,
	input wire        tx_power_down,
	input wire        rx_power_down,
	input wire        fifo_bypass,
	input wire [31:0] tx_word_data,
	input wire [3:0]  tx_special_char_flag,
	input wire [3:0]  force_neg_disparity,
	input wire [39:0] tx_code_out,
	input wire        tx_code_valid,
	input wire        rx_word_valid,
	input wire        rx_aligned,
	input wire [1:0]  channel_addr
);
	// ****************************************************************
	// raw packing and assertions
	// ****************************************************************
	function automatic [39:0] raw_pack(input [31:0] w, input [3:0] s,
		input [3:0] f);
		integer n;
		for (n = 0; n < 4; n = n + 1)
			raw_pack[10*n +: 10] = {s[n], f[n], w[8*n +: 8]};
	endfunction
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	reset_clears_a: assert property (disable iff (1'b0)
		rst |=> !tx_code_valid && !rx_word_valid && tx_code_out == 40'h0
		&& channel_addr == 2'b00) else $error("reset left outputs set");
	addr_value_a: assert property (
		clk_en |=> channel_addr == {BLOCK_ID[0], CHANNEL_ID[0]})
		else $error("channel address wrong");
	raw_packing_a: assert property (
		clk_en && !tx_power_down && !tx_half_rate && !coding_enable |=>
		tx_code_valid && tx_code_out == raw_pack($past(tx_word_data),
		$past(tx_special_char_flag), $past(force_neg_disparity)))
		else $error("raw word packed wrong");
	full_rate_take_a: assert property (
		clk_en && !tx_power_down && !tx_half_rate |=> tx_code_valid)
		else $error("full rate word not taken");
	half_rate_gap_a: assert property (
		clk_en && tx_half_rate && $past(tx_half_rate) && tx_code_valid
		|=> !tx_code_valid) else $error("half rate took twice in a row");
	tx_power_off_a: assert property (
		clk_en && tx_power_down |=> tx_code_out == 40'h0 && !tx_code_valid)
		else $error("powered down transmitter active");
	rx_power_off_a: assert property (
		(rx_power_down && clk_en && fifo_bypass)[*3] |=>
		!rx_word_valid && !rx_aligned)
		else $error("powered down receiver active");
	hold_between_a: assert property (
		!tx_code_valid && !$past(tx_power_down) && !$past(rst) |->
		$stable(tx_code_out)) else $error("code changed without a take");
endmodule // tca_channel_properties

// ### test/tca_fabric_model.sv
// fabric-side model: keeps the latest received word the channel presents
// assumes the channel clock, sampling at the rising edge
`timescale 1ns/1ps
module tca_fabric_model (
	input  wire        clock,
	input  wire        rx_word_valid,
	input  wire [39:0] rx_word_data,
	input  wire [3:0]  rx_lane_error,
	input  wire        rx_frame_pulse,
	output reg  [39:0] got_word,
	output reg  [3:0]  got_err,
	output reg  [15:0] got_count,
	output reg  [15:0] pulse_count
);
	initial begin
		got_word = 40'h0;
		got_err = 4'h0;
		got_count = 16'h0;
		pulse_count = 16'h0;
	end
	always @(posedge clock) begin
		if (rx_word_valid) begin
			got_word <= rx_word_data;
			got_err <= rx_lane_error;
			got_count <= got_count + 16'h1;
		end
		if (rx_frame_pulse)
			pulse_count <= pulse_count + 16'h1;
	end
endmodule // tca_fabric_model

// ### test/tca_channel_bench.sv
// self-checking bench of one transceiver channel with a fabric model
// assumes design sources compiled with shared/ on the include path
`timescale 1ns/1ps
module tca_channel_bench;
	reg         clock, rst, clk_en, coding_enable, decode_enable;
	reg         align_enable, fifo_bypass, tx_half_rate, tx_power_down;
	reg         rx_power_down, loop_high_speed, rx_code_valid;
	reg         group_quad, xaui_mode, loop_low_speed;
	reg  [3:0]  peer_gate;
	reg  [31:0] tx_word_data;
	reg  [3:0]  tx_special_char_flag, force_neg_disparity;
	reg  [39:0] rx_code_in;
	wire [39:0] tx_code_out, rx_word_data, got_word;
	wire [3:0]  rx_lane_error, got_err;
	wire        tx_code_valid, rx_word_valid, rx_frame_pulse;
	wire        rx_marker_seen, rx_aligned;
	wire [1:0]  channel_addr;
	wire [15:0] got_count, pulse_count;
	integer     failures, checks, n, k;

	always #5 clock = ~clock;
	tca_channel #(.BLOCK_ID(1'b1), .CHANNEL_ID(1'b0)) dut_u (
		.clock(clock), .rst(rst), .clk_en(clk_en),
		.coding_enable(coding_enable), .decode_enable(decode_enable),
		.align_enable(align_enable), .fifo_bypass(fifo_bypass),
		.group_quad(group_quad), .xaui_mode(xaui_mode),
		.tx_half_rate(tx_half_rate),
		.rx_half_rate(1'b0), .tx_power_down(tx_power_down),
		.rx_power_down(rx_power_down), .loop_high_speed(loop_high_speed),
		.loop_low_speed(loop_low_speed), .tx_word_data(tx_word_data),
		.tx_special_char_flag(tx_special_char_flag),
		.force_neg_disparity(force_neg_disparity), .rx_code_in(rx_code_in),
		.rx_code_valid(rx_code_valid),
		.peer_marker_seen(peer_gate & {4{rx_marker_seen}}),
		.tx_code_out(tx_code_out),
		.tx_code_valid(tx_code_valid), .rx_word_data(rx_word_data),
		.rx_lane_error(rx_lane_error), .rx_word_valid(rx_word_valid),
		.rx_frame_pulse(rx_frame_pulse), .rx_marker_seen(rx_marker_seen),
		.rx_aligned(rx_aligned), .channel_addr(channel_addr));
	tca_fabric_model fabric_u (
		.clock(clock), .rx_word_valid(rx_word_valid),
		.rx_word_data(rx_word_data), .rx_lane_error(rx_lane_error),
		.rx_frame_pulse(rx_frame_pulse), .got_word(got_word),
		.got_err(got_err), .got_count(got_count),
		.pulse_count(pulse_count));

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task check(input [39:0] got, input [39:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task start(input integer c);
		begin
			rst = 1'b1;
			repeat (c) @(negedge clock);
			rst = 1'b0;
		end
	endtask
	task send(input [31:0] w, input [3:0] s, input [3:0] f,
		input [39:0] exp);
		begin
			tx_word_data = w;
			tx_special_char_flag = s;
			force_neg_disparity = f;
			@(negedge clock);
			check(tx_code_valid, 1'b1);
			check(tx_code_out, exp);
		end
	endtask
	task next_word(input [39:0] exp);
		begin
			k = got_count;
			n = 0;
			while (got_count == k && n < 50) begin
				@(negedge clock);
				n = n + 1;
			end
			if (n == 50)
				check(1'b0, 1'b1);
			check(got_word, exp);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		#20000;
		failures = failures + 1;
		test_done;
	end
	initial begin
		{clock, clk_en, coding_enable, decode_enable, align_enable} = 5'h08;
		{group_quad, xaui_mode, loop_low_speed, peer_gate} = 7'h0f;
		{tx_half_rate, tx_power_down, rx_power_down} = 3'h0;
		{loop_high_speed, rx_code_valid, fifo_bypass} = 3'h1;
		{tx_word_data, tx_special_char_flag, force_neg_disparity} = 40'h0;
		rx_code_in = 40'h0;
		failures = 0;
		checks = 0;
		start(12);
		@(negedge clock);
		check(channel_addr, 2'b10);
		check(tx_code_out, 40'h0);
		send(32'h12345678, 4'b1010, 4'b0110, 40'h84934d5878);
		$display("reset and raw test done");
		start(2);
		coding_enable = 1'b1;
		send(32'hbcbcbcbc, 4'hf, 4'h0, 40'h3eb053eb05);
		send(32'hbcbcbcbc, 4'hf, 4'h4, 40'h3e8fac14fa);
		send(32'hb5b5b5b5, 4'h0, 4'h0, 40'haaaaaaaaaa);
		send(32'h07070707, 4'h0, 4'h0, 40'h1d38b1d38b);
		send(32'hbcbcbcbc, 4'hf, 4'hf, 40'h3e8fa3e8fa);
		// enable low: nothing is taken, the last code stays
		clk_en = 1'b0;
		tx_word_data = 32'h00000000;
		repeat (3) @(negedge clock);
		check(tx_code_out, 40'h3e8fa3e8fa);
		clk_en = 1'b1;
		tx_half_rate = 1'b1;
		k = 0;
		repeat (8) begin
			@(negedge clock);
			k = k + tx_code_valid;
		end
		check(k, 4);
		tx_power_down = 1'b1;
		@(negedge clock);
		check(tx_code_out, 40'h0);
		check(tx_code_valid, 1'b0);
		tx_power_down = 1'b0;
		tx_half_rate = 1'b0;
		$display("coded transmit test done");
		start(2);
		{decode_enable, align_enable, loop_high_speed} = 3'h7;
		tx_word_data = 32'hbcbcbcbc;
		force_neg_disparity = 4'h0;
		repeat (12) @(negedge clock);
		next_word({4{10'h1bc}});
		check(got_err, 4'h0);
		check(rx_aligned, 1'b1);
		check(pulse_count != 16'h0, 1'b1);
		decode_enable = 1'b0;
		repeat (6) @(negedge clock);
		next_word(40'h3eb053eb05);
		{decode_enable, loop_high_speed, rx_code_valid} = 3'h5;
		repeat (6) @(negedge clock);
		next_word(40'h0);
		check(got_err, 4'hf);
		check(rx_aligned, 1'b0);
		rx_power_down = 1'b1;
		repeat (5) @(negedge clock);
		check(rx_word_valid, 1'b0);
		rx_power_down = 1'b0;
		$display("receive bypass test done");
		xaui_mode = 1'b1;
		group_quad = 1'b1;
		peer_gate = 4'h3;
		{fifo_bypass, loop_high_speed, rx_code_valid} = 3'h2;
		repeat (20) @(negedge clock);
		check(rx_marker_seen, 1'b0);
		xaui_mode = 1'b0;
		k = got_count;
		repeat (10) @(negedge clock);
		check(rx_marker_seen, 1'b1);
		check(got_count, k);
		peer_gate = 4'hf;
		next_word({4{10'h1bc}});
		$display("deskew test done");
		loop_low_speed = 1'b1;
		tx_word_data = 32'h12345678;
		tx_special_char_flag = 4'b1010;
		force_neg_disparity = 4'b0110;
		repeat (3) @(negedge clock);
		next_word(40'h84934d5878);
		$display("low speed loop test done");
		test_done;
	end
endmodule // tca_channel_bench

bind tca_channel tca_channel_properties #(
	.BLOCK_ID   (BLOCK_ID),
	.CHANNEL_ID (CHANNEL_ID)
) prop_u (
	.clock(clock), .rst(rst), .clk_en(clk_en),
	.coding_enable(coding_enable), .tx_half_rate(tx_half_rate),
	.tx_power_down(tx_power_down), .rx_power_down(rx_power_down),
	.fifo_bypass(fifo_bypass), .tx_word_data(tx_word_data),
	.tx_special_char_flag(tx_special_char_flag),
	.force_neg_disparity(force_neg_disparity), .tx_code_out(tx_code_out),
	.tx_code_valid(tx_code_valid), .rx_word_valid(rx_word_valid),
	.rx_aligned(rx_aligned), .channel_addr(channel_addr)
);
